// ### amp_port.sv
// sequencer for the multiplexed asynchronous memory port
`timescale 1ns/1ps
module amp_port #(
    parameter int FIFO_DEPTH = amp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // transfer requests
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [15:0] req_addr_i,
    // write data stream
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [15:0] wdata_i,
    // read data
    output logic rdata_valid_o,
    output logic [15:0] rdata_o,
    // configuration
    input wire logic [15:0] port_control_register_i,
    input wire logic wide_mode_i,
    input wire logic hold_enable_i,
    input wire logic flash_mode_i,
    input wire logic ale_active_low_i,
    input wire logic [7:0] external_index_step_i,
    output logic busy_o,
    // external bus
    input wire logic [15:0] muxed_bus_lines_i,
    output logic [15:0] muxed_bus_lines_o,
    output logic [15:0] muxed_bus_lines_oe_o,
    output logic ale_o,
    output logic rd_n_o,
    output logic wr_n_o
);
    amp_pkg::amp_state_e state_q;
    logic div_q;
    logic pclk_en;
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    logic wr_q;
    logic wide_q;
    logic hold_q;
    logic flash_q;
    logic ale_pol_q;
    logic [4:0] dur_q;
    logic [15:0] addr_q;
    logic [15:0] wdat_q;
    logic have_q;
    logic [5:0] cnt_q;
    logic [2:0] left_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic start;
    logic tick_end;
    logic strobe_done;
    logic [5:0] dur_eff;
    logic [5:0] f_ticks;
    logic [5:0] strobe_len;
    logic [2:0] group_n;
    amp_pkg::amp_state_e post_state;
    logic [5:0] post_cnt;

    amp_fifo_if #(.WIDTH(16)) wfifo ();

    amp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .fifo(wfifo.store)
    );

    assign wfifo.push_valid = wdata_valid_i;
    assign wfifo.push_data = wdata_i;
    assign wdata_ready_o = wfifo.push_ready;
    assign wfifo.pop_ready = (state_q == amp_pkg::ST_SETUP) && wr_q && !have_q;

    // ==========================================================
    // peripheral tick divider
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            div_q <= 1'b0;
        end else begin
            div_q <= !div_q; // RL2
        end
    end
    assign pclk_en = div_q;

    // ==========================================================
    // bus input synchroniser
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= muxed_bus_lines_i;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // derived lengths
    assign dur_eff = (dur_q == 5'h00) ? 6'h01 : {1'b0, dur_q}; // RL1
    assign f_ticks = flash_q ? amp_pkg::FLASH_TICKS : 6'h00;
    always_comb begin
        strobe_len = dur_eff;
        if (wr_q && flash_q) begin
            // a too-short duration still gives one tick
            strobe_len = (dur_eff > f_ticks) ? (dur_eff - f_ticks) : 6'h01; // RL4
        end
    end
    always_comb begin
        group_n = amp_pkg::GROUP_LEN; // RL17 RL18
        if (wide_mode_i && (external_index_step_i != 8'h00)) begin
            group_n = 3'h1; // RL19
        end
    end

    assign start = (state_q == amp_pkg::ST_IDLE) && pclk_en && req_valid_i;
    assign req_ready_o = (state_q == amp_pkg::ST_IDLE) && pclk_en;
    assign tick_end = pclk_en && (cnt_q == 6'h01);
    assign strobe_done = tick_end && (((state_q == amp_pkg::ST_STRB) && !hold_q)
                         || (state_q == amp_pkg::ST_HOLD));

    // after a strobe and its hold
    always_comb begin
        if (left_q == 3'h1) begin
            post_state = amp_pkg::ST_TAIL;
            post_cnt = f_ticks + 6'h01; // RL12 RL13 RL14
        end else begin
            post_state = amp_pkg::ST_GAP;
            post_cnt = wr_q ? (f_ticks + 6'h01) : 6'h01; // RL11 RL4
        end
    end

    // ==========================================================
    // transfer settings, caught at the start
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_q <= 1'b0;
            wide_q <= 1'b0;
            hold_q <= 1'b0;
            flash_q <= 1'b0;
            dur_q <= 5'h00;
        end else if (start) begin
            wr_q <= req_write_i;
            wide_q <= wide_mode_i;
            hold_q <= hold_enable_i;
            flash_q <= flash_mode_i;
            dur_q <= port_control_register_i[amp_pkg::DUR_MSB:amp_pkg::DUR_LSB];
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            ale_pol_q <= amp_pkg::ALE_POL_RESET; // RL20
        end else if (state_q == amp_pkg::ST_IDLE) begin
            ale_pol_q <= ale_active_low_i; // RL20
        end
    end

    // address; byte mode steps the upper byte
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            addr_q <= '0;
        end else if (start) begin
            addr_q <= req_addr_i;
        end else if (strobe_done && !wide_q) begin
            addr_q[15:8] <= addr_q[15:8] + 8'h01; // RL17
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            have_q <= 1'b0;
            wdat_q <= '0;
        end else if (wfifo.pop_ready && wfifo.pop_valid) begin
            have_q <= 1'b1;
            wdat_q <= wfifo.pop_data;
        end else if (strobe_done) begin
            have_q <= 1'b0;
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= amp_pkg::ST_IDLE;
            cnt_q <= 6'h00;
            left_q <= 3'h0;
        end else if (start) begin
            state_q <= amp_pkg::ST_ALE;
            cnt_q <= 6'(amp_pkg::ALE_TICKS); // RL6
            left_q <= group_n;
        end else if (pclk_en && (state_q != amp_pkg::ST_IDLE)) begin
            if (cnt_q != 6'h01) begin
                cnt_q <= cnt_q - 6'h01;
            end else begin
                unique case (state_q)
                    amp_pkg::ST_IDLE: begin
                        state_q <= amp_pkg::ST_IDLE;
                    end
                    amp_pkg::ST_ALE: begin
                        state_q <= amp_pkg::ST_AHOLD;
                        cnt_q <= 6'(amp_pkg::ADDR_HOLD_TICKS); // RL6
                    end
                    amp_pkg::ST_AHOLD: begin
                        state_q <= amp_pkg::ST_SETUP;
                        cnt_q <= 6'(amp_pkg::SETUP_TICKS); // RL7 RL8
                    end
                    amp_pkg::ST_SETUP: begin
                        // writes wait for a held word
                        if (!wr_q || have_q) begin
                            state_q <= amp_pkg::ST_STRB;
                            cnt_q <= strobe_len; // RL1 RL16
                        end
                    end
                    amp_pkg::ST_STRB: begin
                        if (hold_q) begin
                            state_q <= amp_pkg::ST_HOLD;
                            cnt_q <= 6'(amp_pkg::HOLD_TICKS); // RL3
                        end else begin
                            state_q <= post_state;
                            cnt_q <= post_cnt;
                            left_q <= left_q - 3'h1;
                        end
                    end
                    amp_pkg::ST_HOLD: begin
                        state_q <= post_state;
                        cnt_q <= post_cnt;
                        left_q <= left_q - 3'h1;
                    end
                    amp_pkg::ST_GAP: begin
                        if (wr_q) begin
                            state_q <= amp_pkg::ST_SETUP;
                            cnt_q <= 6'(amp_pkg::SETUP_TICKS); // RL15
                        end else begin
                            state_q <= amp_pkg::ST_STRB;
                            cnt_q <= strobe_len;
                        end
                    end
                    amp_pkg::ST_TAIL: begin
                        state_q <= amp_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // read capture on the strobe rise
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= tick_end && (state_q == amp_pkg::ST_STRB) && !wr_q;
            if (tick_end && (state_q == amp_pkg::ST_STRB) && !wr_q) begin
                rdata_q <= wide_q ? sync2_q : {8'h00, sync2_q[7:0]}; // RL10
            end
        end
    end
    assign rdata_o = rdata_q;
    assign rdata_valid_o = rvalid_q;

    // ==========================================================
    // pin drive
    assign rd_n_o = !((state_q == amp_pkg::ST_STRB) && !wr_q); // RL21
    assign wr_n_o = !((state_q == amp_pkg::ST_STRB) && wr_q); // RL21
    assign ale_o = (state_q == amp_pkg::ST_ALE) ^ ale_pol_q; // RL6 RL20
    assign busy_o = (state_q != amp_pkg::ST_IDLE);

    always_comb begin
        muxed_bus_lines_o = 16'h0000;
        muxed_bus_lines_oe_o = 16'h0000;
        unique case (state_q)
            amp_pkg::ST_ALE, amp_pkg::ST_AHOLD: begin
                muxed_bus_lines_o = addr_q; // RL6
                muxed_bus_lines_oe_o = 16'hFFFF;
            end
            amp_pkg::ST_SETUP, amp_pkg::ST_STRB, amp_pkg::ST_HOLD, amp_pkg::ST_GAP: begin // RL9
                if (!wide_q) begin
                    muxed_bus_lines_o[15:8] = addr_q[15:8]; // RL15
                    muxed_bus_lines_oe_o[15:8] = 8'hFF;
                    if (wr_q && have_q) begin
                        muxed_bus_lines_o[7:0] = wdat_q[7:0]; // RL16
                        muxed_bus_lines_oe_o[7:0] = 8'hFF;
                    end
                end else if (wr_q && have_q) begin
                    muxed_bus_lines_o = wdat_q; // RL16 RL3
                    muxed_bus_lines_oe_o = 16'hFFFF;
                end
            end
            amp_pkg::ST_IDLE, amp_pkg::ST_TAIL: begin
            end
        endcase
    end

    // ==========================================================
    // checks
    logic [5:0] low_cnt_q;
    logic [5:0] high_cnt_q;
    logic [5:0] since_ale_q;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            low_cnt_q <= 6'h00;
            high_cnt_q <= 6'h3F;
            since_ale_q <= 6'h3F;
        end else begin
            low_cnt_q <= (rd_n_o && wr_n_o) ? 6'h00 : low_cnt_q + 6'h01;
            if (!(rd_n_o && wr_n_o)) begin
                high_cnt_q <= 6'h00;
            end else if (high_cnt_q != 6'h3F) begin
                high_cnt_q <= high_cnt_q + 6'h01;
            end
            if (state_q == amp_pkg::ST_ALE) begin
                since_ale_q <= 6'h00;
            end else if (since_ale_q != 6'h3F) begin
                since_ale_q <= since_ale_q + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    strobes_exclusive_a: assert property (rd_n_o || wr_n_o) // RL21
        else $error("both strobes low");
    idle_strobes_a: assert property (!busy_o |-> rd_n_o && wr_n_o) // RL21
        else $error("strobe while idle");
    tick_alternate_a: assert property (pclk_en |=> !pclk_en ##1 pclk_en) // RL2
        else $error("tick not alternating");
    ale_width_a: assert property ($rose(state_q == amp_pkg::ST_ALE) |-> // RL6
        (ale_o != ale_pol_q) [*4] ##1 (ale_o == ale_pol_q))
        else $error("latch width");
    ale_polarity_a: assert property (!busy_o && !ale_pol_q |-> !ale_o) // RL20
        else $error("latch active while idle");
    rd_after_ale_a: assert property ($fell(rd_n_o) |-> since_ale_q >= 6'h04) // RL7
        else $error("read too soon after latch");
    wr_after_ale_a: assert property ($fell(wr_n_o) |-> since_ale_q >= 6'h04) // RL8
        else $error("write too soon after latch");
    rd_width_a: assert property ($rose(rd_n_o) |-> low_cnt_q == {dur_eff[4:0], 1'b0}) // RL1
        else $error("read width");
    wr_width_a: assert property ($rose(wr_n_o) |-> low_cnt_q == {strobe_len[4:0], 1'b0}) // RL4
        else $error("write width");
    rd_release_a: assert property (!rd_n_o && wide_q |-> muxed_bus_lines_oe_o == 16'h0000) // RL9
        else $error("bus driven in read");
    rd_capture_a: assert property (rdata_valid_o |-> $rose(rd_n_o)) // RL10
        else $error("capture off strobe rise");
    rd_gap_a: assert property ($fell(rd_n_o) |->
        high_cnt_q >= 6'(2 * (32'(hold_q) + 1))) // RL11
        else $error("read gap");
    wr_gap_a: assert property ($fell(wr_n_o) |->
        high_cnt_q >= 6'(2 * (32'(f_ticks) + 32'(hold_q) + 1))) // RL4
        else $error("write gap");
    hold_data_a: assert property (state_q == amp_pkg::ST_HOLD && wr_q |->
        muxed_bus_lines_oe_o[7:0] == 8'hFF) // RL3
        else $error("hold lost data");

    byte_read_c: cover property (state_q == amp_pkg::ST_TAIL && !wide_q && !wr_q);
    word_burst_c: cover property ($rose(rd_n_o) && wide_q && left_q == 3'h2);
    flash_write_c: cover property ($rose(wr_n_o) && flash_q);
    hold_read_c: cover property (state_q == amp_pkg::ST_HOLD && !wr_q);
endmodule // amp_port

// ### amp_pkg.sv
// constants and types for the muxed memory port
// ==========================================================
// Summary of operation
// RL1: strobe low for five-bit duration field periods
// RL2: peripheral tick is every second core clock
// RL3: optional hold period keeps address and data
// RL4: flash mode shortens write, widens write gap
// RL5: software keeps duration at least nine; the bench uses two to six outside flash mode
// RL6: latch strobe two ticks, address around it
// RL7: read strobe two ticks after latch ends
// RL8: write strobe two ticks after latch ends
// RL9: reads release bus after latch phase, except the upper byte in byte mode
// RL10: read data captured at strobe rise
// RL11: read gap at least hold plus one
// RL12: latch waits recovery plus hold after read
// RL13: address drive waits one more tick
// RL14: latch waits recovery plus hold after write
// RL15: byte mode drives upper address byte
// RL16: write data set up before strobe rises
// RL17: byte mode reads four per latch, stepping
// RL18: byte mode writes four per latch
// RL19: word mode one strobe unless step zero
// RL20: latch strobe active high after reset
// RL21: strobes idle high, never both low
package amp_pkg;
    // ==========================================================
    // timing in peripheral ticks, after the core clock period in ns and its divider
    localparam int CLK_PERIOD_NS = 40;
    localparam int PCLK_DIV = 2;
    localparam int ALE_TICKS = 2;
    localparam int ADDR_HOLD_TICKS = 1;
    localparam int SETUP_TICKS = 1;
    localparam int HOLD_TICKS = 1;
    localparam logic [5:0] FLASH_TICKS = 6'h07;
    localparam int FLASH_MIN_DUR = 9;
    localparam logic [2:0] GROUP_LEN = 3'h4;
    // ==========================================================
    // field layout of the port control word
    localparam int DUR_LSB = 1;
    localparam int DUR_MSB = 5;
    localparam logic ALE_POL_RESET = 1'b0;
    localparam int FIFO_DEPTH = 32;
    // ==========================================================
    // sequencer states, gray coded along the path
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ALE   = 3'h1,
        ST_AHOLD = 3'h3,
        ST_SETUP = 3'h2,
        ST_STRB  = 3'h6,
        ST_HOLD  = 3'h7,
        ST_GAP   = 3'h5,
        ST_TAIL  = 3'h4
    } amp_state_e;
endpackage

// ### amp_fifo_if.sv
// carrier between the port and its write fifo
`timescale 1ns/1ps
interface amp_fifo_if #(parameter int WIDTH = 16);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface

// ### amp_fifo.sv
// write data fifo with registered head word
`timescale 1ns/1ps
module amp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = amp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // fill and drain
    amp_fifo_if.store fifo
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic [WIDTH-1:0] head_q;
    logic head_valid_q;
    logic push_fire;
    logic load;

    assign fifo.push_ready = (count_q != (AW+1)'(DEPTH));
    assign push_fire = fifo.push_valid && fifo.push_ready;
    assign load = (count_q != '0) && (!head_valid_q || fifo.pop_ready);
    assign fifo.pop_valid = head_valid_q;
    assign fifo.pop_data = head_q;

    always_ff @(posedge clock_i) begin
        if (push_fire) begin
            mem_q[wr_ptr_q] <= fifo.push_data;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push_fire) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push_fire) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            head_valid_q <= 1'b0;
            head_q <= '0;
        end else if (load) begin
            head_valid_q <= 1'b1;
            head_q <= mem_q[rd_ptr_q];
        end else if (fifo.pop_ready) begin
            head_valid_q <= 1'b0;
        end
    end
endmodule // amp_fifo

// ### amp_mem_model.sv
// far-side memory with address latch on the muxed bus
`timescale 1ns/1ps
module amp_mem_model (
    // clock
    input wire logic clock_i,
    // mode and response delay in cycles
    input wire logic wide_i,
    input wire logic ale_act_i,
    input wire logic [3:0] lag_i,
    // pins
    input wire logic [15:0] bus_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic [15:0] drive_o,
    output logic [15:0] oe_o
);
    // ==========================================================
    // storage and latch
    logic [15:0] mem [logic [15:0]];
    logic [15:0] lat_q = 16'h0000;
    logic [15:0] wkey = 16'h0000;
    logic [15:0] wval = 16'h0000;
    logic p_ale = 1'b0;
    logic p_wr = 1'b1;
    int low_n = 0;
    initial begin
        drive_o = 16'h0000;
        oe_o = 16'h0000;
    end
    // ==========================================================
    // behaviour, between the port's clock edges
    always @(negedge clock_i) begin
        logic [15:0] key;
        logic [15:0] word;
        key = wide_i ? lat_q : {bus_i[15:8], lat_q[7:0]};
        word = mem.exists(key) ? mem[key] : key ^ 16'h5A3C;
        if (p_ale && !ale_act_i) begin
            lat_q = bus_i;
        end
        if (!rd_n_i) begin
            low_n++;
            oe_o = wide_i ? 16'hFFFF : 16'h00FF;
            // wrong data until the access time has run
            drive_o = (low_n > int'(lag_i)) ? word : ~word;
        end else begin
            low_n = 0;
            oe_o = 16'h0000;
        end
        if (!wr_n_i) begin
            wkey = key;
            wval = wide_i ? bus_i : {8'h00, bus_i[7:0]};
        end else if (!p_wr) begin
            mem[wkey] = wval;
        end
        p_ale = ale_act_i;
        p_wr = wr_n_i;
    end
endmodule // amp_mem_model

// ### async_muxed_parallel_memory_port_bench.sv
// self-checking bench for the multiplexed memory port
`timescale 1ns/1ps
module async_muxed_parallel_memory_port_bench;
    // ==========================================================
    // signals and bookkeeping
    logic clock_i, reset_i, req_valid, req_ready, req_write, wd_valid, wd_ready, rd_valid;
    logic wide, hold, flash, ale_low, busy, ale, rd_n, wr_n, ale_act;
    logic p_ale = 1'b0, p_rd = 1'b1, p_wr = 1'b1;
    logic [3:0] lag;
    logic [7:0] step;
    logic [15:0] req_addr, wdata, rdata, pcr, dev_o, dev_oe, mem_o, mem_oe, bus, g_addr;
    logic [15:0] shadow [logic [15:0]];
    logic [15:0] wq [$];
    logic [15:0] rq [$];
    int n_errors = 0, num_checks = 0, cyc = 0, t = 0, t_af = 0, t_sf = 0, t_sr = 0;
    int ale_on = 0, n_strb = 0, gap_min = 0, post_min = 0, dur = 2, g_h = 0, g_f = 0;
    // ==========================================================
    // design, far side and resolved bus
    amp_port #(.FIFO_DEPTH(32)) amp_port_i (
        .clock_i(clock_i), .reset_i(reset_i), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .req_write_i(req_write), .req_addr_i(req_addr),
        .wdata_valid_i(wd_valid), .wdata_ready_o(wd_ready), .wdata_i(wdata),
        .rdata_valid_o(rd_valid), .rdata_o(rdata), .port_control_register_i(pcr),
        .wide_mode_i(wide), .hold_enable_i(hold), .flash_mode_i(flash),
        .ale_active_low_i(ale_low), .external_index_step_i(step), .busy_o(busy),
        .muxed_bus_lines_i(bus), .muxed_bus_lines_o(dev_o),
        .muxed_bus_lines_oe_o(dev_oe), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n));
    amp_mem_model amp_mem_model_i (
        .clock_i(clock_i), .wide_i(wide), .ale_act_i(ale_act), .lag_i(lag), .bus_i(bus),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .drive_o(mem_o), .oe_o(mem_oe));
    assign ale_act = busy & (ale ^ ale_low);
    // free lines toggle so stale values fail
    always_comb begin
        for (int k = 0; k < 16; k++) begin
            bus[k] = dev_oe[k] ? dev_o[k] : (mem_oe[k] ? mem_o[k] : cyc[0] ^ k[0]);
        end
    end
    // ==========================================================
    // expectations and comparisons
    function automatic logic [15:0] exp_word(input logic [15:0] k, input logic w);
        logic [15:0] v;
        v = shadow.exists(k) ? shadow[k] : k ^ 16'h5A3C;
        return w ? v : {8'h00, v[7:0]};
    endfunction
    function automatic logic [15:0] exp_oe(input logic r);
        return r ? (wide ? 16'h0000 : 16'hFF00) : 16'hFFFF;
    endfunction
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_min(input int got, input int lo, input string what);
        num_checks++;
        if (got < lo) begin
            n_errors++;
            $display("mismatch %0t: %s is %0d < %0d", $time, what, got, lo);
        end
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================================
    // clock and hang guard
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // pin monitor, in cycles
    always @(negedge clock_i) begin
        t++;
        if (rd_valid === 1'b1) begin
            rq.push_back(rdata);
        end
        if (ale_act && !p_ale) begin
            ale_on = t;
            if (t_sr > 0) begin
                cmp_min(t - t_sr, post_min, "to latch");
            end
        end
        if (!ale_act && p_ale) begin
            t_af = t;
            n_strb = 0;
            cmp_word(16'(t - ale_on), 16'h0004, "latch width");
            cmp_word(dev_o & dev_oe, g_addr, "address");
        end
        if ((!rd_n && p_rd) || (!wr_n && p_wr)) begin
            if (n_strb == 0) begin
                cmp_min(t - t_af, 4, "to strobe");
            end else begin
                cmp_min(t - t_sr, gap_min, "gap");
            end
            cmp_word(dev_oe, exp_oe(!rd_n), "direction");
            if (!wide) begin
                cmp_word(dev_o[15:8], g_addr[15:8] + 8'(n_strb), "upper address");
            end
            t_sf = t;
        end
        if ((rd_n && !p_rd) || (wr_n && !p_wr)) begin
            cmp_word(16'(t - t_sf), 16'(2 * (!p_rd ? dur : dur - g_f)), "strobe width");
            if (g_h != 0) begin
                cmp_word(dev_oe, exp_oe(!p_rd), "hold drive");
            end
            gap_min = 2 * (g_h + 1 + (p_rd ? g_f : 0));
            post_min = 2 * (p_rd ? g_h : g_f + g_h + 1);
            n_strb++;
            t_sr = t;
        end
        if (!rd_n && !wr_n) begin
            cmp_word(16'h0001, 16'h0000, "both strobes low");
        end
        p_ale = ale_act;
        p_rd = rd_n;
        p_wr = wr_n;
    end
    // ==========================================================
    // drivers
    task automatic fill(input int max, output int n);
        n = 0;
        while (n < max) begin
            @(negedge clock_i);
            if (!wd_ready) break;
            wdata = 16'($urandom);
            wd_valid = 1'b1;
            wq.push_back(wdata);
            n++;
        end
        @(negedge clock_i);
        wd_valid = 1'b0;
    endtask
    task automatic run_group(input logic w, input logic wd, input logic [15:0] a,
                             input int d, input int h, input int f, input logic [7:0] s);
        int n;
        int guard;
        logic [15:0] k;
        logic [15:0] v;
        @(negedge clock_i);
        req_write = w;
        wide = wd;
        req_addr = a;
        step = s;
        pcr = (16'($urandom) & 16'hFFC1) | 16'(d << 1);
        hold = h[0];
        flash = (f != 0);
        lag = 4'($urandom_range(d - 1, 0));
        dur = d;
        g_h = h;
        g_f = f;
        g_addr = a;
        rq.delete();
        req_valid = 1'b1;
        guard = 0;
        while (!req_ready && guard < 8) begin
            @(negedge clock_i);
            guard++;
        end
        @(negedge clock_i);
        req_valid = 1'b0;
        guard = 0;
        while (busy && guard < 3000) begin
            @(negedge clock_i);
            guard++;
        end
        cmp_word(16'(busy), 16'h0000, "done");
        n = (wd && s != 8'h00) ? 1 : 4;
        cmp_word(16'(n_strb), 16'(n), "strobes");
        cmp_word(16'(rq.size()), 16'(w ? 0 : n), "answers");
        for (int i = 0; i < n; i++) begin
            k = wd ? a : {a[15:8] + 8'(i), a[7:0]};
            if (w) begin
                v = wq.pop_front();
                shadow[k] = wd ? v : {8'h00, v[7:0]};
            end else begin
                cmp_word(rq[i], exp_word(k, wd), "read data");
            end
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        int n, d, h;
        logic [15:0] a;
        logic [7:0] s;
        {reset_i, req_valid, req_write, wd_valid, wide, hold, flash, ale_low} = 8'h80;
        {req_addr, wdata, pcr, step, lag} = 60'h0;
        void'($urandom(2));
        repeat (16) @(negedge clock_i);
        reset_i = 1'b0;
        cmp_word({13'h0000, ale, rd_n, wr_n}, 16'h0003, "idle");
        fill(40, n);
        cmp_word(16'(n), 16'h0021, "fill");
        for (int i = 0; i < 9; i++) begin
            a = {8'($urandom_range(250, 0)), 8'($urandom)};
            d = $urandom_range(6, 2);
            h = $urandom_range(1, 0);
            s = 8'($urandom_range(255, 1));
            run_group(1'b1, i == 8, a, d, h, 0, s);
            run_group(1'b0, i == 8, a, d, h, 0, s);
        end
        cmp_word(16'(wd_ready), 16'h0001, "drained");
        for (int i = 0; i < 4; i++) begin
            a = {8'($urandom_range(250, 0)), 8'($urandom)};
            d = $urandom_range(12, 9);
            fill(4, n);
            run_group(1'b1, i[0], a, d, i[1], 7, 8'h00);
            run_group(1'b0, i[0], a, d, i[1], 7, 8'h00);
        end
        @(negedge clock_i);
        ale_low = 1'b1;
        repeat (4) @(negedge clock_i);
        cmp_word(16'(ale), 16'h0001, "latch idle");
        run_group(1'b0, 1'b0, a, 3, 0, 0, 8'h00);
        tally_and_finish();
    end
endmodule // async_muxed_parallel_memory_port_bench
